// file: testbench/pif_top_tb.sv
// Self-checking bench for the peripheral flag block
`include "pif_cfg.svh"
module pif_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic reset_n_in;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic ack;
  logic t0;
  logic ext;
  logic [7:0] pa;
  logic [7:0] pc;
  pif_pkg::pif_byte_t en0;
  pif_pkg::pif_byte_t fl [3];
  logic cpu_irq;
  logic irq;
  logic [31:0] q;
  logic [7:0] en_ofs [3] = '{`PIF_OFS_EN2, `PIF_OFS_EN3, `PIF_OFS_EN4};
  logic [7:0] pats [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
  logic [7:0] ctl [4] = '{8'h81, 8'h41, 8'h01, 8'hC1};
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;

  // 100 MHz system clock
  always #5 clk_in = ~clk_in;

  pif_top pif_top_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
    .wb_ack_out(ack), .timer0_ovf_in(t0), .ext_pin_in(ext),
    .port_a_change_flags_in(pa), .port_c_change_flags_in(pc),
    .req0_enable_in(en0), .req2_flags_in(fl[0]), .req3_flags_in(fl[1]),
    .req4_flags_in(fl[2]), .cpu_irq_req_out(cpu_irq), .irq_out(irq)
  );

  // Verdict and end of run
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; holds the request until ack is sampled
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] rdat);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    @(posedge clk_in);
    while (ack !== 1'b1)
      @(posedge clk_in);
    rdat = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] unused;
    bus(a, 1'b1, {24'h00_0000, d}, 4'h1, unused);
  endtask

  task automatic rd(input string what, input logic [7:0] a,
      input logic [7:0] e);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0000_0000, 4'hF, v);
    check(what, {24'h00_0000, e}, v);
  endtask

  task automatic pulse();
    t0 <= 1'b1;
    @(posedge clk_in);
    t0 <= 1'b0;
    @(posedge clk_in);
  endtask

  // Cut a hang short
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    reset_n_in = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
    t0 = 1'b0;
    ext = 1'b0;
    pa = 8'h00;
    pc = 8'h00;
    en0 = 8'h00;
    fl[0] = 8'h00;
    fl[1] = 8'h00;
    fl[2] = 8'h00;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    // Reset values of every register
    rd("enable2 reset", `PIF_OFS_EN2, 8'h00);
    rd("enable3 reset", `PIF_OFS_EN3, 8'h00);
    rd("enable4 reset", `PIF_OFS_EN4, 8'h00);
    rd("request0 reset", `PIF_OFS_REQ0, 8'h00);
    rd("control reset", `PIF_OFS_CTRL, 8'h01);
    rd("status reset", `PIF_OFS_EVT_STAT, 8'h00);
    rd("mask reset", `PIF_OFS_EVT_MASK, 8'h00);
    check("irq idle", 32'h0000_0000, 32'(irq));
    // Enable bits hold any pattern
    foreach (en_ofs[i])
      foreach (pats[p])
      begin
        wr(en_ofs[i], pats[p]);
        rd("enable pattern", en_ofs[i], pats[p]);
      end
    // per-bit gating, walked one bit at a time
    wr(`PIF_OFS_CTRL, 8'hC1);
    for (int i = 0; i < 3; i++)
      for (int b = 0; b < 8; b++)
      begin
        wr(en_ofs[i], 8'h01 << b);
        fl[i] <= 8'h01 << b;
        repeat (3) @(posedge clk_in);
        check("cpu request own bit", 32'h0000_0001, 32'(cpu_irq));
        fl[i] <= ~(8'h01 << b);
        repeat (3) @(posedge clk_in);
        check("cpu request other bits", 32'h0000_0000, 32'(cpu_irq));
        fl[i] <= 8'h00;
        wr(en_ofs[i], 8'h00);
      end
    wr(`PIF_OFS_EN2, 8'h01);
    fl[0] <= 8'h01;
    foreach (ctl[k])
    begin
      wr(`PIF_OFS_CTRL, ctl[k]);
      repeat (3) @(posedge clk_in);
      check("master gating", 32'(k == 3), 32'(cpu_irq));
    end
    fl[0] <= 8'h00;
    wr(`PIF_OFS_EN2, 8'h00);
    // Flags set with every enable off
    wr(`PIF_OFS_CTRL, 8'h01);
    pulse();
    rd("timer0 flag", `PIF_OFS_REQ0, 8'h20);
    repeat (20) @(posedge clk_in);
    rd("timer0 flag sticky", `PIF_OFS_REQ0, 8'h20);
    wr(`PIF_OFS_REQ0, 8'h00);
    rd("timer0 flag cleared", `PIF_OFS_REQ0, 8'h00);
    wr(`PIF_OFS_REQ0, 8'hFF);
    rd("unimplemented bits", `PIF_OFS_REQ0, 8'h21);
    // event lands on the clearing edge
    fork
      wr(`PIF_OFS_REQ0, 8'h00);
      begin
        @(posedge ack);
        t0 <= 1'b1;
        @(posedge clk_in);
        t0 <= 1'b0;
      end
    join
    rd("set beats clear", `PIF_OFS_REQ0, 8'h20);
    // Request register 0 also reaches the CPU
    wr(`PIF_OFS_CTRL, 8'hC1);
    en0 <= 8'h20;
    repeat (3) @(posedge clk_in);
    check("cpu request timer0", 32'h0000_0001, 32'(cpu_irq));
    en0 <= 8'h00;
    wr(`PIF_OFS_REQ0, 8'h00);
    // External pin, rising then falling selection
    wr(`PIF_OFS_CTRL, 8'h01);
    ext <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd("pin rising", `PIF_OFS_REQ0, 8'h01);
    ext <= 1'b0;
    repeat (8) @(posedge clk_in);
    wr(`PIF_OFS_REQ0, 8'h00);
    wr(`PIF_OFS_CTRL, 8'h00);
    ext <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd("pin rising ignored", `PIF_OFS_REQ0, 8'h00);
    ext <= 1'b0;
    repeat (8) @(posedge clk_in);
    rd("pin falling", `PIF_OFS_REQ0, 8'h01);
    wr(`PIF_OFS_REQ0, 8'h00);
    // Summary of pin change flags is read-only
    pa <= 8'h80;
    wr(`PIF_OFS_REQ0, 8'h00);
    rd("summary port a", `PIF_OFS_REQ0, 8'h10);
    pa <= 8'h00;
    pc <= 8'h01;
    wr(`PIF_OFS_REQ0, 8'h00);
    rd("summary port c", `PIF_OFS_REQ0, 8'h10);
    pc <= 8'h00;
    @(posedge clk_in);
    rd("summary clear", `PIF_OFS_REQ0, 8'h00);
    // Event status, mask and block interrupt
    pulse();
    repeat (2) @(posedge clk_in);
    check("irq masked", 32'h0000_0000, 32'(irq));
    wr(`PIF_OFS_EVT_MASK, 8'h01);
    repeat (2) @(posedge clk_in);
    check("irq unmasked", 32'h0000_0001, 32'(irq));
    wr(`PIF_OFS_EVT_STAT, 8'h01);
    repeat (2) @(posedge clk_in);
    check("irq cleared", 32'h0000_0000, 32'(irq));
    // Pin edges and CPU request rises left their own bits set
    rd("status others kept", `PIF_OFS_EVT_STAT, 8'h06);
    wr(`PIF_OFS_EVT_STAT, 8'h06);
    rd("status cleared", `PIF_OFS_EVT_STAT, 8'h00);
    // Unmapped place and disabled byte lane
    wr(8'h1C, 8'hFF);
    rd("unmapped", 8'h1C, 8'h00);
    bus(`PIF_OFS_EN2, 1'b1, 32'h0000_00FF, 4'hE, q);
    rd("lane off", `PIF_OFS_EN2, 8'h00);
    summarize();
  end
endmodule

// file: verilog/pif_cfg.svh
// Offsets, bit positions and reset values of the peripheral flag block
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH
// Byte offsets on the register bus
`define PIF_OFS_EN2 8'h00
`define PIF_OFS_EN3 8'h04
`define PIF_OFS_EN4 8'h08
`define PIF_OFS_REQ0 8'h0C
`define PIF_OFS_CTRL 8'h10
`define PIF_OFS_EVT_STAT 8'h14
`define PIF_OFS_EVT_MASK 8'h18
// Request register 0 fields
`define PIF_BIT_TMR0 5
`define PIF_BIT_PINCHG 4
`define PIF_BIT_EXT 0
`define PIF_REQ0_IMPL 8'h31
// Control register fields
`define PIF_BIT_GIE 7
`define PIF_BIT_PERIPHERAL_MASTER_ENABLE 6
`define PIF_BIT_EDGE 0
// Event status fields
`define PIF_EVT_TMR0 0
`define PIF_EVT_EXT 1
`define PIF_EVT_CPU 2
`define PIF_EVT_W 3
// Reset values
`define PIF_RST_EN 8'h00
`define PIF_RST_REQ0 8'h00
`define PIF_RST_CTRL 8'h01
`define PIF_RST_EVT 3'h0
`endif

// file: verilog/pif_pin_sync.sv
// Three-stage pin synchroniser with selectable edge detect
module pif_pin_sync (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic pin_in,
  input wire logic rising_sel_in,
  output logic edge_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic agree;
  // First stage is read only by the second
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // A change counts only once stages two and three agree
  assign agree = (s2_reg == s3_reg);
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      level_reg <= 1'b0;
      edge_out <= 1'b0;
    end
    else
    begin
      if (agree)
        level_reg <= s3_reg;
      edge_out <= agree & (s3_reg != level_reg)
                  & (s3_reg == rising_sel_in);
    end
  end
  a_edge_agreed: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) edge_out |-> $past(s2_reg) == $past(s3_reg))
    else $error("edge reported without stage agreement");
endmodule

// file: verilog/pif_pkg.sv
// Types shared by the peripheral flag block
package pif_pkg;
  typedef logic [7:0] pif_byte_t;
  typedef enum logic [2:0] {
    pif_sel_en2, pif_sel_en3, pif_sel_en4, pif_sel_req0,
    pif_sel_ctrl, pif_sel_stat, pif_sel_mask, pif_sel_none
  } pif_reg_sel_t;
endpackage

// file: verilog/pif_reg_if.sv
// Register access path between bus slave and register file
interface pif_reg_if;
  logic [7:0] adr;
  pif_pkg::pif_byte_t wdata;
  logic wr;
  pif_pkg::pif_byte_t rdata;
  modport bus (output adr, output wdata, output wr, input rdata);
  modport regs (input adr, input wdata, input wr, output rdata);
endinterface

// file: verilog/pif_top.sv
// Peripheral interrupt enable and request flag block
//
// Local design decisions: the register addresses and the Wishbone slave port.
`include "pif_cfg.svh"
module pif_top #(
  parameter int PORT_A_W = 8,
  parameter int PORT_C_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic timer0_ovf_in,
  input wire logic ext_pin_in,
  input wire logic [PORT_A_W-1:0] port_a_change_flags_in,
  input wire logic [PORT_C_W-1:0] port_c_change_flags_in,
  input wire pif_pkg::pif_byte_t req0_enable_in,
  input wire pif_pkg::pif_byte_t req2_flags_in,
  input wire pif_pkg::pif_byte_t req3_flags_in,
  input wire pif_pkg::pif_byte_t req4_flags_in,
  output logic cpu_irq_req_out,
  output logic irq_out
);
  import pif_pkg::*;

  pif_reg_if rif ();

  pif_byte_t periph_irq_enable_2_reg;
  pif_byte_t periph_irq_enable_3_reg;
  pif_byte_t periph_irq_enable_4_reg;
  logic timer0_overflow_flag_reg;
  logic external_pin_flag_reg;
  pif_byte_t irq_control_reg;
  logic [`PIF_EVT_W-1:0] evt_stat_reg;
  logic [`PIF_EVT_W-1:0] evt_mask_reg;
  logic [`PIF_EVT_W-1:0] evt_set;
  logic [`PIF_EVT_W-1:0] evt_clr;
  pif_reg_sel_t sel;
  pif_byte_t req0_view;
  pif_byte_t rd_next;
  logic pin_change_summary_flag;
  logic ext_edge;
  logic global_irq_enable;
  logic peripheral_master_enable;
  logic cpu_req_next;
  logic any_req;

  // Bus front end; keeps ack and read data in flip-flops
  pif_wb_slave u_wb (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .cyc_in(wb_cyc_in),
    .stb_in(wb_stb_in),
    .we_in(wb_we_in),
    .adr_in(wb_adr_in),
    .sel_in(wb_sel_in),
    .dat_in(wb_dat_in),
    .dat_out(wb_dat_out),
    .ack_out(wb_ack_out),
    .regs(rif.bus)
  );

  // External pin arrives asynchronously, so it is synchronised here
  pif_pin_sync u_pin (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(ext_pin_in),
    .rising_sel_in(irq_control_reg[`PIF_BIT_EDGE]),
    .edge_out(ext_edge)
  );

  // Address decode
  always_comb
  begin
    case (rif.adr)
      `PIF_OFS_EN2: sel = pif_sel_en2;
      `PIF_OFS_EN3: sel = pif_sel_en3;
      `PIF_OFS_EN4: sel = pif_sel_en4;
      `PIF_OFS_REQ0: sel = pif_sel_req0;
      `PIF_OFS_CTRL: sel = pif_sel_ctrl;
      `PIF_OFS_EVT_STAT: sel = pif_sel_stat;
      `PIF_OFS_EVT_MASK: sel = pif_sel_mask;
      default: sel = pif_sel_none;
    endcase
  end

  // pin change OR
  // Per-pin flags live in the change unit, which only sets them
  // for edges its rising and falling masks allow
  // masked edges only
  assign pin_change_summary_flag = (|port_a_change_flags_in)
                                   | (|port_c_change_flags_in);

  always_comb
  begin
    req0_view = `PIF_RST_REQ0;
    req0_view[`PIF_BIT_TMR0] = timer0_overflow_flag_reg;
    req0_view[`PIF_BIT_PINCHG] = pin_change_summary_flag;
    req0_view[`PIF_BIT_EXT] = external_pin_flag_reg;
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    case (sel)
      pif_sel_en2: rd_next = periph_irq_enable_2_reg;
      pif_sel_en3: rd_next = periph_irq_enable_3_reg;
      pif_sel_en4: rd_next = periph_irq_enable_4_reg;
      pif_sel_req0: rd_next = req0_view;
      pif_sel_ctrl: rd_next = irq_control_reg;
      pif_sel_stat: rd_next = {5'h00, evt_stat_reg};
      pif_sel_mask: rd_next = {5'h00, evt_mask_reg};
      default: rd_next = 8'h00;
    endcase
  end
  assign rif.rdata = rd_next;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      periph_irq_enable_2_reg <= `PIF_RST_EN;
    else if (rif.wr && sel == pif_sel_en2)
      periph_irq_enable_2_reg <= rif.wdata;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      periph_irq_enable_3_reg <= `PIF_RST_EN;
    else if (rif.wr && sel == pif_sel_en3)
      periph_irq_enable_3_reg <= rif.wdata;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      periph_irq_enable_4_reg <= `PIF_RST_EN;
    else if (rif.wr && sel == pif_sel_en4)
      periph_irq_enable_4_reg <= rif.wdata;
  end

  // set beats clear
  // A write of one also sets it, as for the external pin flag
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      timer0_overflow_flag_reg <= 1'b0;
    else if (rif.wr && sel == pif_sel_req0)
      timer0_overflow_flag_reg <= rif.wdata[`PIF_BIT_TMR0]
                                  | timer0_ovf_in;
    else if (timer0_ovf_in)
      timer0_overflow_flag_reg <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      external_pin_flag_reg <= 1'b0;
    else if (rif.wr && sel == pif_sel_req0)
      external_pin_flag_reg <= rif.wdata[`PIF_BIT_EXT] | ext_edge;
    else if (ext_edge)
      external_pin_flag_reg <= 1'b1;
  end

  // Global and peripheral master enables plus pin edge select
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      irq_control_reg <= `PIF_RST_CTRL;
    else if (rif.wr && sel == pif_sel_ctrl)
    begin
      irq_control_reg <= 8'h00;
      irq_control_reg[`PIF_BIT_GIE] <= rif.wdata[`PIF_BIT_GIE];
      irq_control_reg[`PIF_BIT_PERIPHERAL_MASTER_ENABLE] <= rif.wdata[`PIF_BIT_PERIPHERAL_MASTER_ENABLE];
      irq_control_reg[`PIF_BIT_EDGE] <= rif.wdata[`PIF_BIT_EDGE];
    end
  end
  assign global_irq_enable = irq_control_reg[`PIF_BIT_GIE];
  assign peripheral_master_enable = irq_control_reg[`PIF_BIT_PERIPHERAL_MASTER_ENABLE];

  // flag and enable
  // All sources here are peripheral ones, so both enables apply
  assign any_req = (|(periph_irq_enable_2_reg & req2_flags_in))
                   | (|(periph_irq_enable_3_reg & req3_flags_in))
                   | (|(periph_irq_enable_4_reg & req4_flags_in))
                   | (|(req0_enable_in & req0_view));
  assign cpu_req_next = global_irq_enable & peripheral_master_enable
                        & any_req;

  // Registered so the CPU sees a glitch-free level
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cpu_irq_req_out <= 1'b0;
    else
      cpu_irq_req_out <= cpu_req_next;
  end

  // Block events feeding the sticky status register
  assign evt_set = {cpu_req_next & ~cpu_irq_req_out, ext_edge,
                    timer0_ovf_in};
  assign evt_clr = (rif.wr && sel == pif_sel_stat)
                   ? rif.wdata[`PIF_EVT_W-1:0] : `PIF_RST_EVT;

  // Write one to clear; a fresh event in the same cycle survives
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      evt_stat_reg <= `PIF_RST_EVT;
    else
      evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
  end

  // Mask register, same layout as the status
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      evt_mask_reg <= `PIF_RST_EVT;
    else if (rif.wr && sel == pif_sel_mask)
      evt_mask_reg <= rif.wdata[`PIF_EVT_W-1:0];
  end

  // One cycle behind the status, traded for a flop-driven output
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(evt_stat_reg & evt_mask_reg);
  end

  // Checks on the register and request behaviour
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  logic wr_req0;
  assign wr_req0 = rif.wr && sel == pif_sel_req0;

  a_enables_reset: assert property ($rose(reset_n_in) |->
    periph_irq_enable_2_reg == 8'h00 &&
    periph_irq_enable_3_reg == 8'h00 &&
    periph_irq_enable_4_reg == 8'h00)
    else $error("enable registers not clear after reset");

  a_en2_write: assert property (rif.wr && sel == pif_sel_en2 |=>
    periph_irq_enable_2_reg == $past(rif.wdata))
    else $error("enable register two write lost");

  a_en3_write: assert property (rif.wr && sel == pif_sel_en3 |=>
    periph_irq_enable_3_reg == $past(rif.wdata))
    else $error("enable register three write lost");

  a_en4_write: assert property (rif.wr && sel == pif_sel_en4 |=>
    periph_irq_enable_4_reg == $past(rif.wdata))
    else $error("enable register four write lost");

  a_tmr0_sticky: assert property (timer0_overflow_flag_reg &&
    !(wr_req0 && !rif.wdata[`PIF_BIT_TMR0]) |=>
    timer0_overflow_flag_reg)
    else $error("timer0 flag dropped without a zero write");

  a_ext_set: assert property (ext_edge && !global_irq_enable |=>
    external_pin_flag_reg)
    else $error("external pin flag not set by event");

  a_flag_indep: assert property (timer0_ovf_in && !cpu_req_next
    |=> timer0_overflow_flag_reg)
    else $error("timer0 flag depends on enables");

  a_set_wins: assert property (timer0_ovf_in && wr_req0 &&
    !rif.wdata[`PIF_BIT_TMR0] |=> timer0_overflow_flag_reg)
    else $error("software clear beat hardware set");

  a_pinchg_read: assert property (wb_cyc_in && wb_stb_in &&
    !wb_we_in && !wb_ack_out && wb_adr_in == `PIF_OFS_REQ0 |=>
    wb_dat_out[`PIF_BIT_PINCHG] == $past(pin_change_summary_flag))
    else $error("pin change bit does not mirror flags");

  a_pinchg_cause: assert property (pin_change_summary_flag |->
    (port_a_change_flags_in != '0) ||
    (port_c_change_flags_in != '0))
    else $error("summary flag without a pin flag");

  a_reserved_zero: assert property (
    (req0_view & ~`PIF_REQ0_IMPL) == 8'h00)
    else $error("reserved request bits read non-zero");

  a_periph_gate: assert property (!peripheral_master_enable |=>
    !cpu_irq_req_out)
    else $error("request passed with peripheral enable off");

  a_global_gate: assert property (!global_irq_enable |=>
    !cpu_irq_req_out)
    else $error("request passed with global enable off");

  a_cpu_request: assert property (global_irq_enable &&
    peripheral_master_enable &&
    |(periph_irq_enable_2_reg & req2_flags_in) |=>
    cpu_irq_req_out)
    else $error("enabled request not forwarded");

  // Main scenarios the bench is expected to reach
  c_tmr0_set: cover property (timer0_ovf_in ##1
    timer0_overflow_flag_reg);
  c_cpu_irq: cover property ($rose(cpu_irq_req_out));
  c_set_clear: cover property (timer0_ovf_in && wr_req0);
  c_block_irq: cover property ($rose(irq_out));
  c_ext_flag: cover property (ext_edge ##1 external_pin_flag_reg);
endmodule

// file: verilog/pif_wb_slave.sv
// Classic Wishbone slave front end with one wait state
module pif_wb_slave (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cyc_in,
  input wire logic stb_in,
  input wire logic we_in,
  input wire logic [7:0] adr_in,
  input wire logic [3:0] sel_in,
  input wire logic [31:0] dat_in,
  output logic [31:0] dat_out,
  output logic ack_out,
  pif_reg_if.bus regs
);
  import pif_pkg::*;
  logic req;
  assign req = cyc_in & stb_in;
  // Address and data pass straight to the register file
  assign regs.adr = adr_in;
  assign regs.wdata = dat_in[7:0];
  // Write lands on the edge where the master sees ack
  assign regs.wr = req & we_in & ack_out & sel_in[0];
  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ack_out <= 1'b0;
    else
      ack_out <= req & ~ack_out;
  end
  // Read data captured with the ack, upper bits zero
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      dat_out <= 32'h0000_0000;
    else if (req & ~ack_out & ~we_in)
      dat_out <= {24'h00_0000, regs.rdata};
  end
  a_ack_single: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) ack_out |=> !ack_out)
    else $error("ack held for more than one cycle");
endmodule
